// File: fovr_pkg.sv
package fovr_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [7:0] FOVR_ADDR_FET = 8'h00;
  localparam logic [7:0] FOVR_ADDR_LDO = 8'h01;

  // ==========================================================================
  // Field positions.
  localparam int FOVR_BIT_PRECHARGE_OFF    = 3;
  localparam int FOVR_BIT_CHARGE_OFF       = 2;
  localparam int FOVR_BIT_PREDISCHARGE_OFF = 1;
  localparam int FOVR_BIT_DISCHARGE_OFF    = 0;
  localparam int FOVR_BIT_LDO_EN           = 0;
  localparam int FOVR_LSB_LDO_SEL          = 1;

  // ==========================================================================
  // Reset values.
  localparam logic [3:0] FOVR_RST_FET = 4'h0;
  localparam logic [3:0] FOVR_RST_LDO = 4'h0;

  // ==========================================================================
  // Regulator output levels.
  typedef enum logic [2:0] {
    FOVR_LVL_1V8,
    FOVR_LVL_2V5,
    FOVR_LVL_3V0,
    FOVR_LVL_3V3,
    FOVR_LVL_5V0
  } fovr_level_t;

  // Requests from the turn-on logic and the gated driver controls.
  typedef struct packed {
    logic precharge_fet;
    logic charge_fet;
    logic predischarge_fet;
    logic discharge_fet;
  } fovr_fet_t;

endpackage

// File: fovr_level_dec.sv
`timescale 1ns/10ps
`default_nettype none
module fovr_level_dec
  import fovr_pkg::*;
(
  input  wire logic [2:0] sel,   // Level-select code.
  output fovr_level_t     level  // Decoded output level.
);

  // ==========================================================================
  // Codes 0 to 3 share the lowest level.
  always_comb begin
    unique case (sel)
      3'h4:    level = FOVR_LVL_2V5;
      3'h5:    level = FOVR_LVL_3V0;
      3'h6:    level = FOVR_LVL_3V3;
      3'h7:    level = FOVR_LVL_5V0;
      default: level = FOVR_LVL_1V8;
    endcase
  end

endmodule
`default_nettype wire

// File: fovr_ctrl.sv
// Overview of operation
// - Bit 3 of the override register holds the precharge driver off.
// - Bit 2 of the override register holds the charge driver off.
// - Bit 1 of the override register holds the predischarge driver off.
// - Bit 0 of the override register holds the discharge driver off.
// - A clear force-off bit passes its driver's turn-on request unchanged.
// - Regulator bits 3 to 1 select 1.8V for codes 0 to 3 and 2.5V for 4.
// - Regulator codes 5, 6 and 7 select 3V, 3.3V and 5V.
// - Regulator bit 0 enables the regulator when one.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module fovr_ctrl
  import fovr_pkg::*;
(
  input  wire logic       mclk,        // System clock, 250 MHz.
  input  wire logic       rst_n,       // Synchronous reset, active low.
  input  wire logic [7:0] addr,        // Register address.
  input  wire logic [7:0] wdata,       // Write data.
  input  wire logic       wr,          // Write strobe.
  input  wire logic       rd,          // Read strobe.
  output logic      [7:0] rdata,       // Read data, cycle after rd.
  input  wire fovr_fet_t  fet_req,     // Turn-on requests.
  output fovr_fet_t       fet_drv,     // Gated driver controls.
  output logic            ldo_one_enable,    // Regulator enable.
  output fovr_level_t     ldo_one_level      // Regulator level.
);

  // ==========================================================================
  // Register state.
  logic [3:0]  fet_q, fet_d;
  logic [3:0]  ldo_q, ldo_d;
  logic [7:0]  rdata_d;
  fovr_fet_t   drv_d;
  fovr_level_t lvl_d;
  logic        precharge_force_off;
  logic        charge_force_off;
  logic        predischarge_force_off;
  logic        discharge_force_off;
  logic [2:0]  ldo_one_level_sel;

  assign precharge_force_off    = fet_q[FOVR_BIT_PRECHARGE_OFF];
  assign charge_force_off       = fet_q[FOVR_BIT_CHARGE_OFF];
  assign predischarge_force_off = fet_q[FOVR_BIT_PREDISCHARGE_OFF];
  assign discharge_force_off    = fet_q[FOVR_BIT_DISCHARGE_OFF];
  assign ldo_one_level_sel      = ldo_q[FOVR_LSB_LDO_SEL +: 3];

  fovr_level_dec u_dec (
    .sel   (ldo_one_level_sel),
    .level (lvl_d)
  );

  // Writes keep only bits 3 to 0; reads zero-fill the upper nibble.
  always_comb begin
    fet_d   = fet_q;
    ldo_d   = ldo_q;
    rdata_d = 8'h00;
    if (wr && addr == FOVR_ADDR_FET) begin
      fet_d = wdata[3:0];
    end
    if (wr && addr == FOVR_ADDR_LDO) begin
      ldo_d = wdata[3:0];
    end
    if (rd && addr == FOVR_ADDR_FET) begin
      rdata_d = {4'h0, fet_q};
    end
    if (rd && addr == FOVR_ADDR_LDO) begin
      rdata_d = {4'h0, ldo_q};
    end
  end

  // Driver gating: a set force-off bit wins over any request.
  always_comb begin
    drv_d.precharge_fet    = fet_req.precharge_fet
                             & ~precharge_force_off;
    drv_d.charge_fet       = fet_req.charge_fet
                             & ~charge_force_off;
    drv_d.predischarge_fet = fet_req.predischarge_fet
                             & ~predischarge_force_off;
    drv_d.discharge_fet    = fet_req.discharge_fet
                             & ~discharge_force_off;
  end

  // Register everything; outputs come straight from flops.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fet_q          <= FOVR_RST_FET;
      ldo_q          <= FOVR_RST_LDO;
      rdata          <= 8'h00;
      fet_drv        <= '0;
      ldo_one_enable <= 1'b0;
      ldo_one_level  <= FOVR_LVL_1V8;
    end else begin
      fet_q          <= fet_d;
      ldo_q          <= ldo_d;
      rdata          <= rdata_d;
      fet_drv        <= drv_d;
      ldo_one_enable <= ldo_q[FOVR_BIT_LDO_EN];
      ldo_one_level  <= lvl_d;
    end
  end

  // ==========================================================================
  // Assertions.
  property p_pre_off;
    @(posedge mclk) disable iff (!rst_n)
    precharge_force_off |=> !fet_drv.precharge_fet;
  endproperty
  a_pre_off: assert property (p_pre_off)
    else $error("Precharge not held off.");

  property p_charge_off;
    @(posedge mclk) disable iff (!rst_n)
    charge_force_off |=> !fet_drv.charge_fet;
  endproperty
  a_charge_off: assert property (p_charge_off)
    else $error("Charge not held off.");

  property p_predis_off;
    @(posedge mclk) disable iff (!rst_n)
    predischarge_force_off |=> !fet_drv.predischarge_fet;
  endproperty
  a_predis_off: assert property (p_predis_off)
    else $error("Predischarge on.");

  property p_dis_off;
    @(posedge mclk) disable iff (!rst_n)
    discharge_force_off |=> !fet_drv.discharge_fet;
  endproperty
  a_dis_off: assert property (p_dis_off)
    else $error("Discharge not held off.");

  property p_pass;
    @(posedge mclk) disable iff (!rst_n)
    (!charge_force_off && fet_req.charge_fet) |=> fet_drv.charge_fet;
  endproperty
  a_pass: assert property (p_pass) else $error("Charge request lost.");

  // Clear force-off bits pass the other three requests as well.
  property p_pre_pass;
    @(posedge mclk) disable iff (!rst_n)
    (!precharge_force_off && fet_req.precharge_fet)
      |=> fet_drv.precharge_fet;
  endproperty
  a_pre_pass: assert property (p_pre_pass)
    else $error("Precharge request lost.");

  property p_predis_pass;
    @(posedge mclk) disable iff (!rst_n)
    (!predischarge_force_off && fet_req.predischarge_fet)
      |=> fet_drv.predischarge_fet;
  endproperty
  a_predis_pass: assert property (p_predis_pass)
    else $error("Predischarge request lost.");

  property p_dis_pass;
    @(posedge mclk) disable iff (!rst_n)
    (!discharge_force_off && fet_req.discharge_fet)
      |=> fet_drv.discharge_fet;
  endproperty
  a_dis_pass: assert property (p_dis_pass)
    else $error("Discharge request lost.");

  sequence s_wr_ldo4;
    wr && addr == FOVR_ADDR_LDO && wdata[3:1] == 3'h4;
  endsequence
  property p_lvl;
    @(posedge mclk) disable iff (!rst_n)
    s_wr_ldo4 ##1 !(wr && addr == FOVR_ADDR_LDO)
      |=> ldo_one_level == FOVR_LVL_2V5;
  endproperty
  a_lvl: assert property (p_lvl) else $error("Code 4 not 2.5V.");

  property p_lvl7;
    @(posedge mclk) disable iff (!rst_n)
    ldo_one_level_sel == 3'h7 |=> ldo_one_level == FOVR_LVL_5V0;
  endproperty
  a_lvl7: assert property (p_lvl7) else $error("Code 7 not 5V.");

  // The four lowest codes share the lowest level.
  property p_lvl_low;
    @(posedge mclk) disable iff (!rst_n)
    (ldo_one_level_sel <= 3'h3) |=> ldo_one_level == FOVR_LVL_1V8;
  endproperty
  a_lvl_low: assert property (p_lvl_low)
    else $error("Low code not 1.8V.");

  property p_lvl5;
    @(posedge mclk) disable iff (!rst_n)
    ldo_one_level_sel == 3'h5 |=> ldo_one_level == FOVR_LVL_3V0;
  endproperty
  a_lvl5: assert property (p_lvl5)
    else $error("Code 5 not 3V.");

  property p_lvl6;
    @(posedge mclk) disable iff (!rst_n)
    ldo_one_level_sel == 3'h6 |=> ldo_one_level == FOVR_LVL_3V3;
  endproperty
  a_lvl6: assert property (p_lvl6)
    else $error("Code 6 not 3.3V.");

  property p_en;
    @(posedge mclk) disable iff (!rst_n)
    (wr && addr == FOVR_ADDR_LDO && wdata[0]) ##1 !wr |=> ldo_one_enable;
  endproperty
  a_en: assert property (p_en) else $error("Regulator not enabled.");

  // A clear enable bit turns the regulator off one cycle later.
  property p_ldo_off;
    @(posedge mclk) disable iff (!rst_n)
    !ldo_q[FOVR_BIT_LDO_EN] |=> !ldo_one_enable;
  endproperty
  a_ldo_off: assert property (p_ldo_off)
    else $error("Regulator not disabled.");

  property p_rsvd;
    @(posedge mclk) disable iff (!rst_n)
    rd |=> rdata[7:4] == 4'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("Reserved bits nonzero.");

  // Writes keep the low nibble of the data and drop the rest.
  property p_wr_fet;
    @(posedge mclk) disable iff (!rst_n)
    (wr && addr == FOVR_ADDR_FET)
      |=> {4'h0, fet_q} == ($past(wdata) & 8'h0F);
  endproperty
  a_wr_fet: assert property (p_wr_fet)
    else $error("Override write wrong.");

  property p_wr_ldo;
    @(posedge mclk) disable iff (!rst_n)
    (wr && addr == FOVR_ADDR_LDO)
      |=> {4'h0, ldo_q} == ($past(wdata) & 8'h0F);
  endproperty
  a_wr_ldo: assert property (p_wr_ldo)
    else $error("Regulator write wrong.");

  // Reads return the register with a zero upper nibble.
  property p_rd_fet;
    @(posedge mclk) disable iff (!rst_n)
    (rd && addr == FOVR_ADDR_FET) |=> rdata == {4'h0, $past(fet_q)};
  endproperty
  a_rd_fet: assert property (p_rd_fet)
    else $error("Override read wrong.");

  property p_rd_ldo;
    @(posedge mclk) disable iff (!rst_n)
    (rd && addr == FOVR_ADDR_LDO) |=> rdata == {4'h0, $past(ldo_q)};
  endproperty
  a_rd_ldo: assert property (p_rd_ldo)
    else $error("Regulator read wrong.");

  // Read data stand for one cycle only and are zero otherwise.
  property p_rd_idle;
    @(posedge mclk) disable iff (!rst_n)
    !rd |=> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("Read data not cleared.");

endmodule
`default_nettype wire

// File: fovr_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Self-checking bench for the force-off and regulator control block.
module testbench
  import fovr_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst_n;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  fovr_fet_t   fet_req;
  fovr_fet_t   fet_drv;
  logic        ldo_one_enable;
  fovr_level_t ldo_one_level;
  int          n_errors = 0;
  int          samples_checked = 0;
  fovr_level_t lvl_tab [8] = '{FOVR_LVL_1V8, FOVR_LVL_1V8, FOVR_LVL_1V8,
    FOVR_LVL_1V8, FOVR_LVL_2V5, FOVR_LVL_3V0, FOVR_LVL_3V3, FOVR_LVL_5V0};

  fovr_ctrl u_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .fet_req(fet_req), .fet_drv(fet_drv),
    .ldo_one_enable(ldo_one_enable), .ldo_one_level(ldo_one_level));

  // The clock toggles every half period of 2 ns.
  always #2 mclk = ~mclk;

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One write cycle, strobe dropped at the next edge.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  // One read cycle; the data are taken in the cycle after the strobe.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // ==========================================================================
  // Scenarios.
  // Every force pattern against two request patterns, then read back.
  task automatic t_fet();
    logic [3:0] req;
    for (int i = 0; i < 32; i++) begin
      req = i[4] ? 4'hF : 4'h6;
      @(posedge mclk);
      fet_req <= req;
      wr_reg(FOVR_ADDR_FET, {4'hF, i[3:0]});
      @(posedge mclk);
      #1;
      chk({4'h0, fet_drv}, {4'h0, req & ~i[3:0]});
      rd_chk(FOVR_ADDR_FET, {4'h0, i[3:0]});
    end
  endtask

  // Every level code with the enable toggling, reserved bits 7 and 5 set.
  task automatic t_ldo();
    for (int i = 0; i < 16; i++) begin
      wr_reg(FOVR_ADDR_LDO, {4'hA, i[3:0]});
      @(posedge mclk);
      #1;
      chk({5'h00, ldo_one_level}, {5'h00, lvl_tab[i[3:1]]});
      chk({7'h00, ldo_one_enable}, {7'h00, i[0]});
      rd_chk(FOVR_ADDR_LDO, {4'h0, i[3:0]});
    end
    rd_chk(8'h02, 8'h00);
  endtask

  // A write, a read and an unmapped write with no gap between strobes.
  task automatic t_b2b();
    @(posedge mclk);
    addr  <= FOVR_ADDR_LDO;
    wdata <= 8'h09;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
    rd    <= 1'b1;
    @(posedge mclk);
    addr  <= 8'h02;
    wdata <= 8'h00;
    rd    <= 1'b0;
    wr    <= 1'b1;
    #1;
    chk(rdata, 8'h09);
    @(posedge mclk);
    wr    <= 1'b0;
    #1;
    chk(rdata, 8'h00);
    chk({5'h00, ldo_one_level}, {5'h00, FOVR_LVL_2V5});
    rd_chk(FOVR_ADDR_LDO, 8'h09);
    rd_chk(FOVR_ADDR_FET, 8'h0F);
  endtask

  // A reset in mid-run clears both registers and every output.
  task automatic t_rst();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk({4'h0, fet_drv}, 8'h00);
    chk({7'h00, ldo_one_enable}, 8'h00);
    chk({5'h00, ldo_one_level}, {5'h00, FOVR_LVL_1V8});
    rd_chk(FOVR_ADDR_FET, {4'h0, FOVR_RST_FET});
    rd_chk(FOVR_ADDR_LDO, {4'h0, FOVR_RST_LDO});
    chk({4'h0, fet_drv}, {4'h0, fet_req});
  endtask

  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence: reset, reset values, then the scenarios.
  initial begin
    rst_n   <= 1'b0;
    addr    <= 8'h00;
    wdata   <= 8'h00;
    wr      <= 1'b0;
    rd      <= 1'b0;
    fet_req <= 4'hF;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd_chk(FOVR_ADDR_FET, {4'h0, FOVR_RST_FET});
    rd_chk(FOVR_ADDR_LDO, {4'h0, FOVR_RST_LDO});
    chk({4'h0, fet_drv}, 8'h0F);
    t_fet();
    t_ldo();
    t_b2b();
    t_rst();
    give_verdict();
  end
endmodule
`default_nettype wire
